// *** pkg/i2carb_defines.svh ***
`ifndef I2CARB_DEFINES_SVH
`define I2CARB_DEFINES_SVH
// register byte offsets
`define I2CARB_CTRL_ADDR   4'h0
`define I2CARB_STAT_ADDR   4'h4
`define I2CARB_RATE_ADDR   4'h8
`define I2CARB_DATA_ADDR   4'hc
// control register fields
`define I2CARB_CTRL_EN     0
`define I2CARB_CTRL_START  1
`define I2CARB_CTRL_RSTART 2
`define I2CARB_CTRL_STOP   3
`define I2CARB_CTRL_ACK    4
`define I2CARB_CTRL_ACKDT  5
`define I2CARB_CTRL_IRQEN  6
`define I2CARB_CTRL_SLEEP  7
// status register fields
`define I2CARB_ST_BF       0
`define I2CARB_ST_START    3
`define I2CARB_ST_STOP     4
`define I2CARB_ST_WRITE_COLLISION_FLAG     5
`define I2CARB_ST_BCL      6
`define I2CARB_ST_PIRQ     7
// reset values
`define I2CARB_RATE_RST    7'h04
`endif

// *** pkg/i2carb_pkg.sv ***
package i2carb_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_S1    = 4'b0001,
    ST_S2    = 4'b0010,
    ST_R1    = 4'b0011,
    ST_R2    = 4'b0100,
    ST_R3    = 4'b0101,
    ST_R4    = 4'b0110,
    ST_P1    = 4'b0111,
    ST_P2    = 4'b1000,
    ST_P3    = 4'b1001,
    ST_P4    = 4'b1010,
    ST_TXL   = 4'b1011,
    ST_TXH   = 4'b1100,
    ST_AK1   = 4'b1101,
    ST_AK2   = 4'b1110
  } i2carb_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2carb_lines_t;
endpackage

// *** src/i2carb_core.sv ***
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "i2carb_defines.svh"
// What this block does
// - buffer write during stop sets write collision, buffer unchanged
// - counter holds while released clock line is not yet seen high
// - on clock seen high, counter reloads from low seven reload bits
// - in sleep, completed byte wakes processor if port interrupt enabled
// - reset disables the port and aborts any transfer
// - start-seen and stop-seen cleared by reset and by disable
// - bus busy with interrupt enabled: stop on bus raises port interrupt
// - sampled data line compared with driven level; mismatch flags collision
// - expected one but sampled zero with clock high: collision, go idle
// - transmit collision: stop shifting, clear buffer full, release lines
// - sequence collision: abort, release lines, clear request bits
// - after collision keep watching; stop on bus sets port interrupt
// - buffer write after collision restarts at first data bit
// - start with a line already low: abort, flag collision, go idle
// - start: data high loads counter; clock low with data high collides
// - data low during first start count: reset counter, drive data now
// - else drive data low at count end, recount, then drive clock low
// - repeated start: count, release clock, on high sample data, low collides
// - clock falling before timeout while data undriven flags collision
// - both high at timeout: drive data low, count, drive clock low
// - stop: timeout data low, or clock low before data release, collides
// - stop seen on data rise with clock high; one period later irq, clear
module i2carb_core (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  output logic             wake_o
);
  i2carb_pkg::i2carb_state_t state_ff;
  i2carb_pkg::i2carb_lines_t meta_ff, sync_ff, prev_ff;
  logic [6:0] rate_reload_register_ff;
  logic [6:0] bit_rate_counter_ff;
  logic [7:0] shift_data_buffer_ff;
  logic [7:0] shreg_ff;
  logic [3:0] bitcnt_ff;
  logic       en_ff, start_req_ff, rstart_req_ff, stop_request_bit_ff, ack_req_ff;
  logic       ackdt_ff, irqen_ff, sleep_ff;
  logic       buffer_full_flag_ff, write_collision_flag_ff, collision_irq_flag_ff;
  logic       port_irq_flag_ff, start_seen_ff, stop_seen_ff;
  logic       drv_scl_low_ff, drv_sda_low_ff, ack_ff, wake_ff;
  logic       wr, rd, cnt_zero, bus_start, bus_stop, coll, seq_done, abort;

  // two flops before any logic reads the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 2'b11;
      sync_ff <= 2'b11;
      prev_ff <= 2'b11;
    end else begin
      meta_ff <= '{scl: scl_i, sda: sda_i};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign bus_start = sync_ff.scl & prev_ff.sda & ~sync_ff.sda;
  assign bus_stop  = sync_ff.scl & ~prev_ff.sda & sync_ff.sda;
  assign cnt_zero  = (bit_rate_counter_ff == 7'h00);
  assign wr        = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd        = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  // lines driven low: oe_n low, data fixed at zero
  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign scl_oe_n_o = ~drv_scl_low_ff;
  assign sda_oe_n_o = ~drv_sda_low_ff;
  assign wake_o     = wake_ff;

  // collision detection per phase
  always_comb begin
    coll = 1'b0;
    case (state_ff)
      i2carb_pkg::ST_IDLE: coll = start_req_ff & (~sync_ff.sda | ~sync_ff.scl);
      i2carb_pkg::ST_S1:   coll = sync_ff.sda & ~sync_ff.scl;
      i2carb_pkg::ST_R3:   coll = sync_ff.scl & ~sync_ff.sda;
      i2carb_pkg::ST_R4:   coll = prev_ff.scl & ~sync_ff.scl & sync_ff.sda;
      i2carb_pkg::ST_P2:   coll = ~sync_ff.scl & prev_ff.scl;
      i2carb_pkg::ST_P3:   coll = ~sync_ff.scl;
      i2carb_pkg::ST_P4:   coll = cnt_zero & ~sync_ff.sda;
      // driven one but sampled zero while clock high
      i2carb_pkg::ST_TXH,
      i2carb_pkg::ST_AK2:  coll = ~drv_sda_low_ff & sync_ff.scl & ~sync_ff.sda;
      default:             coll = 1'b0;
    endcase
  end
  assign abort = coll | ~en_ff;

  // main sequencer, counter and line drivers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff            <= i2carb_pkg::ST_IDLE;
      bit_rate_counter_ff <= 7'h00;
      drv_scl_low_ff      <= 1'b0;
      drv_sda_low_ff      <= 1'b0;
      shreg_ff            <= 8'h00;
      bitcnt_ff           <= 4'h0;
    end else if (abort) begin
      // release both lines and park
      state_ff       <= i2carb_pkg::ST_IDLE;
      drv_scl_low_ff <= 1'b0;
      drv_sda_low_ff <= 1'b0;
      bitcnt_ff      <= 4'h0;
    end else begin
      if (!cnt_zero) bit_rate_counter_ff <= bit_rate_counter_ff - 7'h01;
      case (state_ff)
        i2carb_pkg::ST_IDLE: begin
          if (start_req_ff) begin
            state_ff            <= i2carb_pkg::ST_S1;
            bit_rate_counter_ff <= rate_reload_register_ff;
          end else if (rstart_req_ff) begin
            drv_sda_low_ff      <= 1'b0;
            state_ff            <= i2carb_pkg::ST_R1;
          end else if (stop_request_bit_ff) begin
            drv_sda_low_ff      <= 1'b1;
            drv_scl_low_ff      <= 1'b1;
            state_ff            <= i2carb_pkg::ST_P1;
          end else if (ack_req_ff) begin
            drv_scl_low_ff      <= 1'b1;
            drv_sda_low_ff      <= ~ackdt_ff;
            bit_rate_counter_ff <= rate_reload_register_ff;
            state_ff            <= i2carb_pkg::ST_AK1;
          end else if (wr && wb_adr_i == `I2CARB_DATA_ADDR && drv_scl_low_ff) begin
            shreg_ff            <= wb_dat_i[7:0];
            bitcnt_ff           <= 4'h0;
            drv_sda_low_ff      <= ~wb_dat_i[7];
            bit_rate_counter_ff <= rate_reload_register_ff;
            state_ff            <= i2carb_pkg::ST_TXL;
          end
        end
        i2carb_pkg::ST_S1: begin
          if (!sync_ff.sda) begin
            drv_sda_low_ff      <= 1'b1;
            bit_rate_counter_ff <= rate_reload_register_ff;
            state_ff            <= i2carb_pkg::ST_S2;
          end else if (cnt_zero) begin
            drv_sda_low_ff      <= 1'b1;
            bit_rate_counter_ff <= rate_reload_register_ff;
            state_ff            <= i2carb_pkg::ST_S2;
          end
        end
        i2carb_pkg::ST_S2: if (cnt_zero) begin
          drv_scl_low_ff <= 1'b1;
          state_ff       <= i2carb_pkg::ST_IDLE;
        end
        i2carb_pkg::ST_R1: if (sync_ff.sda) begin
          bit_rate_counter_ff <= rate_reload_register_ff;
          state_ff            <= i2carb_pkg::ST_R2;
        end
        i2carb_pkg::ST_R2: if (cnt_zero) begin
          drv_scl_low_ff <= 1'b0;
          state_ff       <= i2carb_pkg::ST_R3;
        end
        i2carb_pkg::ST_R3: begin
          // counter held until the clock line is really high
          bit_rate_counter_ff <= rate_reload_register_ff;
          if (sync_ff.scl) state_ff <= i2carb_pkg::ST_R4;
        end
        i2carb_pkg::ST_R4: if (cnt_zero) begin
          if (!drv_sda_low_ff) begin
            drv_sda_low_ff      <= 1'b1;
            bit_rate_counter_ff <= rate_reload_register_ff;
          end else begin
            drv_scl_low_ff <= 1'b1;
            state_ff       <= i2carb_pkg::ST_IDLE;
          end
        end
        i2carb_pkg::ST_P1: if (!sync_ff.sda) begin
          drv_scl_low_ff <= 1'b0;
          state_ff       <= i2carb_pkg::ST_P2;
        end
        i2carb_pkg::ST_P2: begin
          bit_rate_counter_ff <= rate_reload_register_ff;
          if (sync_ff.scl) state_ff <= i2carb_pkg::ST_P3;
        end
        i2carb_pkg::ST_P3: if (cnt_zero) begin
          drv_sda_low_ff      <= 1'b0;
          bit_rate_counter_ff <= rate_reload_register_ff;
          state_ff            <= i2carb_pkg::ST_P4;
        end
        i2carb_pkg::ST_P4: if (cnt_zero) state_ff <= i2carb_pkg::ST_IDLE;
        i2carb_pkg::ST_TXL: if (cnt_zero) begin
          drv_scl_low_ff <= 1'b0;
          state_ff       <= i2carb_pkg::ST_TXH;
        end
        i2carb_pkg::ST_TXH: begin
          if (!sync_ff.scl) begin
            bit_rate_counter_ff <= rate_reload_register_ff;
          end else if (cnt_zero) begin
            drv_scl_low_ff      <= 1'b1;
            bit_rate_counter_ff <= rate_reload_register_ff;
            shreg_ff            <= {shreg_ff[6:0], 1'b1};
            bitcnt_ff           <= bitcnt_ff + 4'h1;
            // after eight bits the slave owns data for its answer
            drv_sda_low_ff      <= (bitcnt_ff < 4'h7) ? ~shreg_ff[6] : 1'b0;
            state_ff            <= (bitcnt_ff == 4'h8) ? i2carb_pkg::ST_IDLE
                                                       : i2carb_pkg::ST_TXL;
          end
        end
        i2carb_pkg::ST_AK1: if (cnt_zero) begin
          drv_scl_low_ff <= 1'b0;
          state_ff       <= i2carb_pkg::ST_AK2;
        end
        i2carb_pkg::ST_AK2: begin
          if (!sync_ff.scl) begin
            bit_rate_counter_ff <= rate_reload_register_ff;
          end else if (cnt_zero) begin
            drv_scl_low_ff <= 1'b1;
            state_ff       <= i2carb_pkg::ST_IDLE;
          end
        end
        default: state_ff <= i2carb_pkg::ST_IDLE;
      endcase
    end
  end

  assign seq_done = ~abort & cnt_zero & ((state_ff == i2carb_pkg::ST_S2) |
                    (state_ff == i2carb_pkg::ST_R4 & drv_sda_low_ff) |
                    (state_ff == i2carb_pkg::ST_AK2 & sync_ff.scl));

  // control and reload registers written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff                   <= 1'b0;
      irqen_ff                <= 1'b0;
      sleep_ff                <= 1'b0;
      ackdt_ff                <= 1'b0;
      rate_reload_register_ff <= `I2CARB_RATE_RST;
    end else if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == `I2CARB_CTRL_ADDR) begin
        en_ff    <= wb_dat_i[`I2CARB_CTRL_EN];
        ackdt_ff <= wb_dat_i[`I2CARB_CTRL_ACKDT];
        irqen_ff <= wb_dat_i[`I2CARB_CTRL_IRQEN];
        sleep_ff <= wb_dat_i[`I2CARB_CTRL_SLEEP];
      end
      if (wb_adr_i == `I2CARB_RATE_ADDR) rate_reload_register_ff <= wb_dat_i[6:0];
    end
  end

  // request bits: set by software only when idle, cleared by hardware
  always_ff @(posedge clk_i) begin
    if (rst_i || abort) begin
      start_req_ff        <= 1'b0;
      rstart_req_ff       <= 1'b0;
      stop_request_bit_ff <= 1'b0;
      ack_req_ff          <= 1'b0;
    end else begin
      if (seq_done) begin
        start_req_ff  <= 1'b0;
        rstart_req_ff <= 1'b0;
        ack_req_ff    <= 1'b0;
      end
      if (state_ff == i2carb_pkg::ST_P4 && cnt_zero) stop_request_bit_ff <= 1'b0;
      if (wr && wb_sel_i[0] && wb_adr_i == `I2CARB_CTRL_ADDR &&
          state_ff == i2carb_pkg::ST_IDLE && !start_req_ff && !rstart_req_ff &&
          !stop_request_bit_ff && !ack_req_ff) begin
        start_req_ff        <= wb_dat_i[`I2CARB_CTRL_START];
        rstart_req_ff       <= wb_dat_i[`I2CARB_CTRL_RSTART];
        stop_request_bit_ff <= wb_dat_i[`I2CARB_CTRL_STOP];
        ack_req_ff          <= wb_dat_i[`I2CARB_CTRL_ACK];
      end
    end
  end

  // buffer and its full and write-collision flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_data_buffer_ff    <= 8'h00;
      buffer_full_flag_ff     <= 1'b0;
      write_collision_flag_ff <= 1'b0;
    end else begin
      if (wr && wb_sel_i[0] && wb_adr_i == `I2CARB_DATA_ADDR) begin
        if (state_ff != i2carb_pkg::ST_IDLE || stop_request_bit_ff) begin
          write_collision_flag_ff <= 1'b1;
        end else begin
          shift_data_buffer_ff <= wb_dat_i[7:0];
          buffer_full_flag_ff  <= 1'b1;
        end
      end else if (wr && wb_sel_i[0] && wb_adr_i == `I2CARB_STAT_ADDR &&
                   !wb_dat_i[`I2CARB_ST_WRITE_COLLISION_FLAG]) begin
        write_collision_flag_ff <= 1'b0;
      end
      if (abort || (state_ff == i2carb_pkg::ST_TXH && bitcnt_ff == 4'h7 && cnt_zero))
        buffer_full_flag_ff <= 1'b0;
    end
  end

  // bus status flags: set wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_ff) begin
      start_seen_ff         <= 1'b0;
      stop_seen_ff          <= 1'b0;
      collision_irq_flag_ff <= 1'b0;
      port_irq_flag_ff      <= 1'b0;
      wake_ff               <= 1'b0;
    end else begin
      if (bus_start) begin
        start_seen_ff <= 1'b1;
        stop_seen_ff  <= 1'b0;
      end else if (bus_stop) begin
        stop_seen_ff  <= 1'b1;
        start_seen_ff <= 1'b0;
      end
      if (coll) collision_irq_flag_ff <= 1'b1;
      else if (wr && wb_sel_i[0] && wb_adr_i == `I2CARB_STAT_ADDR &&
               !wb_dat_i[`I2CARB_ST_BCL]) collision_irq_flag_ff <= 1'b0;
      if ((bus_stop && irqen_ff) || seq_done ||
          (state_ff == i2carb_pkg::ST_P4 && cnt_zero && !coll) ||
          (state_ff == i2carb_pkg::ST_TXH && bitcnt_ff == 4'h8 && cnt_zero))
        port_irq_flag_ff <= 1'b1;
      else if (wr && wb_sel_i[0] && wb_adr_i == `I2CARB_STAT_ADDR &&
               !wb_dat_i[`I2CARB_ST_PIRQ]) port_irq_flag_ff <= 1'b0;
      // wake only while asleep with interrupt enabled
      wake_ff <= sleep_ff & irqen_ff & port_irq_flag_ff;
    end
  end

  // wishbone slave: ack one cycle after strobe, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd) begin
        case (wb_adr_i)
          `I2CARB_CTRL_ADDR: wb_dat_o <= {24'h000000, sleep_ff, irqen_ff, ackdt_ff,
                              ack_req_ff, stop_request_bit_ff, rstart_req_ff,
                              start_req_ff, en_ff};
          `I2CARB_STAT_ADDR: wb_dat_o <= {24'h000000, port_irq_flag_ff,
                              collision_irq_flag_ff, write_collision_flag_ff,
                              stop_seen_ff, start_seen_ff, 2'b00, buffer_full_flag_ff};
          `I2CARB_RATE_ADDR: wb_dat_o <= {25'h0000000, rate_reload_register_ff};
          `I2CARB_DATA_ADDR: wb_dat_o <= {24'h000000, shift_data_buffer_ff};
          default:           wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  stop_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == i2carb_pkg::ST_P4 && cnt_zero && en_ff && !coll) |=> port_irq_flag_ff)
    else $error("stop end did not raise port irq");
  write_collision_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_sel_i[0] && wb_adr_i == `I2CARB_DATA_ADDR && stop_request_bit_ff)
    |=> write_collision_flag_ff && $stable(shift_data_buffer_ff))
    else $error("write during stop not refused");
  coll_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (coll && en_ff) |=> state_ff == i2carb_pkg::ST_IDLE && !drv_sda_low_ff
                        && collision_irq_flag_ff)
    else $error("collision did not idle");
  hold_cnt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == i2carb_pkg::ST_P2 && en_ff) |=> bit_rate_counter_ff == $past(rate_reload_register_ff))
    else $error("counter not held");
  start_chk_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == i2carb_pkg::ST_IDLE && start_req_ff && !sync_ff.scl) |=> !start_req_ff)
    else $error("start with low clock not aborted");
  flags_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_ff |=> !start_seen_ff && !stop_seen_ff)
    else $error("status flags survive disable");
  bcl_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (collision_irq_flag_ff && en_ff && !wr) |=> collision_irq_flag_ff)
    else $error("collision flag dropped");
  stop_seen_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_stop && en_ff) |=> stop_seen_ff)
    else $error("stop not seen");
endmodule

// *** tb/i2carb_bus_model.sv ***
`timescale 1ns/1ps
// other parties on the shared two-wire bus: stretch, grab and a foreign stop
module i2carb_bus_model (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire i2carb_pkg::i2carb_lines_t grab_i,
  input  wire logic                      frame_i,
  output i2carb_pkg::i2carb_lines_t      low_o
);
  logic [6:0] frame_ff;

  // foreign stop frame: clock low for 160 ns, stop 160 ns after it rises; the clock stands still between frames
  always_ff @(posedge clk_i) begin
    if (rst_i)
      frame_ff <= 7'h00;
    else if (frame_i)
      frame_ff <= 7'h78;
    else if (frame_ff != 7'h00)
      frame_ff <= frame_ff - 7'h01;
  end

  // open drain: only ever pulls low, the pull-up gives the high level
  assign low_o.scl = grab_i.scl || (frame_ff > 7'h50);
  assign low_o.sda = grab_i.sda || ((frame_ff > 7'h28) && (frame_ff <= 7'h64)); // data low only while clock low first
endmodule

// *** tb/i2carb_core_bench.sv ***
`timescale 1ns/1ps
`include "i2carb_defines.svh"
`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end
module i2carb_core_bench;
  localparam logic [3:0]  a_ct = `I2CARB_CTRL_ADDR;
  localparam logic [3:0]  a_st = `I2CARB_STAT_ADDR;
  localparam logic [3:0]  a_dt = `I2CARB_DATA_ADDR;
  localparam logic [31:0] c_on = (32'h1 << `I2CARB_CTRL_EN) | (32'h1 << `I2CARB_CTRL_IRQEN);
  localparam logic [31:0] c_st = 32'h1 << `I2CARB_CTRL_START;
  localparam logic [31:0] c_rs = 32'h1 << `I2CARB_CTRL_RSTART;
  localparam logic [31:0] c_sp = 32'h1 << `I2CARB_CTRL_STOP;
  localparam logic [31:0] c_sl = 32'h1 << `I2CARB_CTRL_SLEEP;
  localparam int          b_bf = `I2CARB_ST_BF;
  localparam int          b_bc = `I2CARB_ST_BCL;
  localparam int          b_pi = `I2CARB_ST_PIRQ;
  localparam int          b_p  = `I2CARB_ST_STOP;
  logic                      clk;
  logic                      rst;
  logic [3:0]                wb_adr;
  logic [31:0]               wb_wdat;
  logic [31:0]               wb_rdat;
  logic                      wb_we;
  logic                      wb_cyc;
  logic                      wb_stb;
  logic                      wb_ack;
  logic                      scl_oe_n;
  logic                      sda_oe_n;
  logic                      wake;
  logic                      frame;
  i2carb_pkg::i2carb_lines_t grab;
  i2carb_pkg::i2carb_lines_t low;
  logic                      scl_bus;
  logic                      sda_bus;
  logic [31:0]               q;
  logic [6:0]                rl;
  logic [7:0]                d;
  integer                    seed;
  int                        n;
  int                        fail_count;
  int                        compares;

  // wired-and of all parties with the pull-up
  assign scl_bus = scl_oe_n & ~low.scl;
  assign sda_bus = sda_oe_n & ~low.sda;

  always #2 clk = ~clk;

  i2carb_core i_i2carb_core (
    .clk_i      (clk),
    .rst_i      (rst),
    .wb_adr_i   (wb_adr),
    .wb_dat_i   (wb_wdat),
    .wb_dat_o   (wb_rdat),
    .wb_we_i    (wb_we),
    .wb_sel_i   (4'hf),
    .wb_cyc_i   (wb_cyc),
    .wb_stb_i   (wb_stb),
    .wb_ack_o   (wb_ack),
    .scl_i      (scl_bus),
    .scl_o      (),
    .scl_oe_n_o (scl_oe_n),
    .sda_i      (sda_bus),
    .sda_o      (),
    .sda_oe_n_o (sda_oe_n),
    .wake_o     (wake)
  );

  i2carb_bus_model i_i2carb_bus_model (
    .clk_i   (clk),
    .rst_i   (rst),
    .grab_i  (grab),
    .frame_i (frame),
    .low_o   (low)
  );

  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // classic cycle: request held until ack is sampled, then a cycle idle
  task automatic wb(input logic [3:0] a, input logic [31:0] dw, input logic w);
    int k;
    wb_adr <= a;
    wb_wdat <= dw;
    wb_we <= w;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack !== 1'b1 && k < 40);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk);
    if (k >= 40) begin
      fail_count++;
      $display("Error wb_ack expected 1 seen timeout");
      summarize();
    end
  endtask

  // poll one status bit, bounded
  task automatic wait_st(input int b, input logic v);
    for (int k = 0; k < 400; k++) begin
      wb(a_st, 32'h0, 1'b0);
      if (q[b] === v)
        return;
    end
    fail_count++;
    $display("Error status bit %0d expected %b seen timeout", b, v);
    summarize();
  endtask

  // wait for scl_oe_n (0), sda_oe_n (1) or the clock wire (2); n counts cycles
  task automatic wait_ln(input int s, input logic v);
    logic [2:0] x;
    for (n = 0; n < 3000; n++) begin
      x = {scl_bus, sda_oe_n, scl_oe_n};
      if (x[s] === v)
        return;
      @(posedge clk);
    end
    fail_count++;
    $display("Error line %0d expected %b seen timeout", s, v);
    summarize();
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wb_adr = 4'h0;
    wb_wdat = 32'h0;
    wb_we = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    frame = 1'b0;
    grab = 2'b00;
    seed = 32'hfd56a93f;
    fail_count = 0;
    compares = 0;
    rl = 7'(3 + ($random(seed) & 7));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    `CHK("pins", 3'b110, {scl_oe_n, sda_oe_n, wake})
    wb(a_st, 32'h0, 1'b0);
    `CHK("status", 32'h0, q)
    wb(`I2CARB_RATE_ADDR, 32'h0, 1'b0);
    `CHK("reload", {25'h0, `I2CARB_RATE_RST}, q)
    wb(4'h2, 32'h0, 1'b0);
    `CHK("unmapped", 32'h0, q)
    wb(`I2CARB_RATE_ADDR, {25'h0, rl}, 1'b1);
    $display("test reset done");
    // start refused while another party holds data, then clock, low
    for (int k = 0; k < 2; k++) begin
      grab <= k ? 2'b10 : 2'b01;
      wb(a_ct, c_on, 1'b1);
      wb(a_ct, c_on | c_st, 1'b1);
      wait_st(b_bc, 1'b1);
      wb(a_ct, 32'h0, 1'b0);
      `CHK("start request", 32'h0, q & c_st)
      `CHK("lines", 2'b11, {scl_oe_n, sda_oe_n})
      repeat (20) @(posedge clk);
      wb(a_st, 32'h0, 1'b0);
      `CHK("sticky", 1'b1, q[b_bc])
      grab <= 2'b00;
      wb(a_st, 32'h0, 1'b1);
      wb(a_st, 32'h0, 1'b0);
      `CHK("cleared", 1'b0, q[b_bc])
      wb(a_ct, 32'h0, 1'b1);
      wb(a_st, 32'h0, 1'b0);
      `CHK("bus flags", 32'h0, q & 32'h18)
    end
    $display("test start collision done");
    // start, then stop with the clock stretched and a buffer write refused
    `CHK("bus free", 1'b1, q[b_p] | ~(q[b_p] | q[`I2CARB_ST_START]))
    // a request in the same write that enables is dropped, so enable first
    wb(a_ct, c_on, 1'b1);
    wb(a_ct, c_on | c_st, 1'b1);
    wait_ln(0, 1'b0);
    `CHK("data held", 1'b0, sda_oe_n)
    wb(a_st, 32'h0, 1'b0);
    `CHK("start seen", 1'b1, q[`I2CARB_ST_START])
    grab <= 2'b10;
    d = 8'($random(seed));
    wb(a_ct, c_on | c_sp, 1'b1);
    wb(a_dt, {24'h0, d}, 1'b1);
    wb(a_st, 32'h0, 1'b0);
    `CHK("write_collision_flag", 2'b10, {q[`I2CARB_ST_WRITE_COLLISION_FLAG], q[b_bf]})
    wait_ln(0, 1'b1);
    repeat (30) @(posedge clk);
    `CHK("stretched", 1'b0, sda_oe_n)
    grab <= 2'b00;
    wait_ln(2, 1'b1);
    wait_ln(1, 1'b1);
    `CHK("high time", 1'b1, n >= rl)
    wait_st(b_p, 1'b1);
    wait_st(b_pi, 1'b1);
    wb(a_ct, 32'h0, 1'b0);
    `CHK("stop request", 32'h0, q & c_sp)
    wb(a_st, ~(32'h1 << `I2CARB_ST_WRITE_COLLISION_FLAG), 1'b1);
    wb(a_st, 32'h0, 1'b0);
    `CHK("write_collision_flag cleared", 2'b01, {q[`I2CARB_ST_WRITE_COLLISION_FLAG], q[b_p]})
    $display("test stop done");
    // another master wins with a zero while a one is sent
    `CHK("bus free", 1'b1, q[b_p])
    wb(a_ct, c_on | c_st, 1'b1);
    wait_ln(0, 1'b0);
    d = 8'h80 | 8'($random(seed));
    wb(a_dt, {24'h0, d}, 1'b1);
    wb(a_st, 32'h0, 1'b0);
    `CHK("buffer full", 1'b1, q[b_bf])
    grab <= 2'b01;
    wait_st(b_bc, 1'b1);
    `CHK("bf after loss", 1'b0, q[b_bf])
    `CHK("lines after loss", 2'b11, {scl_oe_n, sda_oe_n})
    grab <= 2'b00;
    // let the stop from the release pass before clearing
    repeat (4) @(posedge clk);
    wb(a_st, 32'h0, 1'b1);
    wb(a_st, 32'h0, 1'b0);
    `CHK("irq clear", 1'b0, q[b_pi])
    frame <= 1'b1;
    @(posedge clk);
    frame <= 1'b0;
    wait_st(b_pi, 1'b1);
    $display("test transmit collision done");
    // fresh byte starts at its first bit; completion wakes from sleep
    wb(a_ct, c_on | c_sl | c_st, 1'b1);
    wait_ln(0, 1'b0);
    wb(a_st, 32'h0, 1'b1);
    d = 8'($random(seed));
    wb(a_dt, {24'h0, d}, 1'b1);
    wait_ln(0, 1'b1);
    `CHK("first bit", d[7], sda_oe_n)
    wait_st(b_pi, 1'b1);
    `CHK("wake", 1'b1, wake)
    $display("test restart done");
    // repeated start and stop both lose to data held low
    for (int k = 0; k < 2; k++) begin
      wb(a_ct, 32'h0, 1'b1);
      wb(a_ct, c_on, 1'b1);
      wb(a_ct, c_on | c_st, 1'b1);
      wait_ln(0, 1'b0);
      repeat (4) @(posedge clk);
      wb(a_ct, c_on | (k ? c_sp : c_rs), 1'b1);
      // data must be low before the clock is seen high again
      wait_ln(1 - k, 1'b1);
      repeat (2) @(posedge clk);
      grab <= 2'b01;
      wait_st(b_bc, 1'b1);
      wb(a_ct, 32'h0, 1'b0);
      `CHK("request", 32'h0, q & (c_rs | c_sp))
      `CHK("released", 2'b11, {scl_oe_n, sda_oe_n})
      grab <= 2'b00;
      wb(a_st, 32'h0, 1'b1);
    end
    $display("test sequence collision done");
    summarize();
  end
endmodule
